// File: verilog/gauge_result_pkg.sv
// Purpose: Shared constants and carriers for the gauge result register bank.
// Assumes: 125 MHz core clock, byte-wide command reads from the host port.
// Notes: Command addresses are byte addresses; each result is a byte pair.
package gauge_result_pkg;

	// Clock and time base.
	localparam int CLK_PERIOD_NS = 8;
	localparam longint ONE_SECOND_NS = 1000000000;
	localparam int SEC_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS);

	// Even command addresses of the result words.
	localparam logic [7:0] ADDR_TIME_TO_FULL = 8'h18;
	localparam logic [7:0] ADDR_IDLE_CURRENT = 8'h1A;
	localparam logic [7:0] ADDR_IDLE_RUNTIME = 8'h1C;
	localparam logic [7:0] ADDR_PEAK_LOAD = 8'h1E;
	localparam logic [7:0] ADDR_PEAK_RUNTIME = 8'h20;
	localparam logic [7:0] ADDR_MEAN_POWER = 8'h24;
	localparam logic [7:0] ADDR_FIXED_POWER_RUNTIME = 8'h26;
	localparam logic [7:0] ADDR_HEALTH = 8'h28;
	localparam logic [7:0] ADDR_CYCLE_COUNT = 8'h2A;
	localparam logic [7:0] ADDR_CHARGE_PERCENT = 8'h2C;
	localparam logic [7:0] ADDR_CELL_IMPEDANCE = 8'h2E;
	localparam logic [7:0] ADDR_INSTANT_CURRENT = 8'h30;
	localparam logic [7:0] ADDR_LOG_FILL = 8'h32;
	localparam logic [7:0] ADDR_LOG_SAMPLE = 8'h34;
	localparam logic [7:0] ADDR_DIE_TEMP = 8'h36;

	// Fixed values and limits.
	localparam logic [15:0] NOT_AVAILABLE = 16'hFFFF;
	localparam logic [15:0] LOG_EMPTY_WORD = 16'h7FFF;
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
	localparam logic [7:0] HEALTH_PCT_MAX = 8'h64;
	localparam logic [7:0] HEALTH_STATUS_MAX = 8'h03;
	localparam logic [15:0] CHARGE_PCT_MAX = 16'h0064;
	localparam logic [15:0] HALF_CHARGE_PCT = 16'h0032;
	localparam logic [15:0] CYCLE_COUNT_MAX = 16'hFFFF;
	localparam int LOG_DEPTH = 30;
	localparam logic [4:0] LOG_LAST_SLOT = 5'h1D;
	localparam logic [4:0] LOG_FULL_COUNT = 5'h1E;
	localparam int FILTER_SHIFT = 4;
	localparam int CELL_PROFILES = 2;

	// Measurements and computed values delivered by the gauging engine.
	typedef struct packed {
		logic signed [15:0] mean_current_ma;
		logic signed [15:0] conv_current_ma;
		logic signed [15:0] mean_power_mw;
		logic [15:0] ttf_minutes;
		logic [15:0] idle_runtime_minutes;
		logic [15:0] peak_runtime_minutes;
		logic [15:0] fixed_power_runtime_minutes;
		logic [7:0] health_pct;
		logic [7:0] health_status;
		logic [15:0] charge_pct;
		logic [15:0] impedance_mohm;
		logic [15:0] die_temp_0p1k;
		logic charging;
		logic discharging;
		logic full_charge;
	} gauge_meas_t;

	// Programmed settings held in non-volatile storage elsewhere.
	typedef struct packed {
		logic [15:0] init_standby_ma;
		logic [15:0] init_max_load_ma;
		logic [15:0] deadband_ma;
		logic [15:0] cycle_threshold_mah;
	} gauge_cfg_t;

endpackage : gauge_result_pkg

// File: verilog/gauge_result_registers.sv
// Purpose: Read-only result register bank of a fuel gauge with a current data log FIFO.
// Assumes: Engine values and host strobes are synchronous to core_clk_i.
// Notes: Host reads bytes; the even byte freezes the word, the odd byte returns its top half.
//
// What this block does
// - Time to full reads 65535 unless charging.
// - Idle current starts at programmed standby value.
// - Idle filter steps each second within window.
// - First and last window samples are skipped.
// - New estimate is 15/16 old plus 1/16 new.
// - Idle runtime reads 65535 unless discharging.
// - Peak load grows to any larger discharge current.
// - Full after deep discharge averages peak with initial.
// - Peak runtime reads 65535 unless discharging.
// - Mean power signed, zero when idle.
// - Fixed power runtime per second, 65535 at zero.
// - Health percent clamped to 0x64.
// - Health status codes 0 to 3 only.
// - Cycle count steps at discharge threshold.
// - Two profile counters, active one cleared on new pack.
// - Charge percent never above 100.
// - Instant current latched once per second.
// - Fill count follows pushes and host reads.
// - Fill count saturates at 30, extra dropped.
// - Log port gives oldest sample or 0x7FFF.
// - Only log commands start or stop logging.
// - Die temperature reported in 0.1 K units.
// - Log on sets active, empties FIFO, blocks sleep.
// - Log off stops capture, keeps stored samples.
`timescale 1ns/1ps
module gauge_result_registers import gauge_result_pkg::*; #(
	parameter int SECOND_CYCLES = SEC_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire gauge_meas_t meas_i,
	input wire gauge_cfg_t cfg_i,
	input wire logic cell_profile_i,
	input wire logic pack_inserted_i,
	input wire logic dsg_step_valid_i,
	input wire logic [15:0] dsg_step_mah_i,
	input wire logic cc_sample_valid_i,
	input wire logic signed [15:0] cc_sample_ma_i,
	input wire logic log_on_subcommand_i,
	input wire logic log_off_subcommand_i,
	input wire logic rd_strobe_i,
	input wire logic [7:0] cmd_addr_i,
	output logic [7:0] rd_data_o,
	output logic log_active_bit_o,
	output logic sleep_inhibit_o
);

	// One-second time base; the engine refreshes its own values at the same rate.
	logic [31:0] sec_cnt_ff;
	logic sec_tick;
	assign sec_tick = (sec_cnt_ff == 32'(SECOND_CYCLES - 1));

	// The counter wraps on the tick so every tick is exactly one second apart.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sec_cnt_ff <= 32'h0;
		end else begin
			sec_cnt_ff <= sec_tick ? 32'h0 : sec_cnt_ff + 32'h1;
		end
	end

	// Discharge magnitude of the averaged current; charge reads as zero.
	logic [15:0] dsg_mag;
	assign dsg_mag = meas_i.mean_current_ma[15] ? 16'(-meas_i.mean_current_ma) : 16'h0;

	// Standby window test; the doubled limit is widened so it cannot wrap.
	logic idle_in_window;
	assign idle_in_window = (dsg_mag > cfg_i.deadband_ma) &&
		({1'b0, dsg_mag} <= {cfg_i.init_standby_ma, 1'b0});

	// Idle filter state: estimate magnitude, a held sample and window progress.
	logic [15:0] idle_est_ff;
	logic [15:0] idle_pend_ff;
	logic idle_pend_vld_ff;
	logic idle_seen_ff;
	logic idle_learned_ff;
	logic [19:0] idle_blend;

	// Fifteen sixteenths of the old value plus one sixteenth of the new sample.
	assign idle_blend = ({4'h0, idle_est_ff} << FILTER_SHIFT) - {4'h0, idle_est_ff}
		+ {4'h0, idle_pend_ff};

	// A sample is only folded in when the next second is also in the window, so the
	// last sample of a window is dropped; the first one is discarded by idle_seen_ff.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			idle_est_ff <= 16'h0;
			idle_pend_ff <= 16'h0;
			idle_pend_vld_ff <= 1'b0;
			idle_seen_ff <= 1'b0;
			idle_learned_ff <= 1'b0;
		end else if (!idle_learned_ff) begin
			// Track the programmed value until the first measurement lands.
			idle_est_ff <= cfg_i.init_standby_ma;
			if (sec_tick) begin
				idle_seen_ff <= idle_in_window;
				idle_pend_vld_ff <= idle_in_window && idle_seen_ff;
				idle_pend_ff <= dsg_mag;
				if (idle_in_window && idle_pend_vld_ff) begin
					idle_learned_ff <= 1'b1;
				end
			end
		end else if (sec_tick) begin
			idle_seen_ff <= idle_in_window;
			idle_pend_vld_ff <= idle_in_window && idle_seen_ff;
			idle_pend_ff <= dsg_mag;
			if (idle_in_window && idle_pend_vld_ff) begin
				idle_est_ff <= idle_blend[19:FILTER_SHIFT];
			end
		end
	end

	// The learned flag only moves the switch point; the first fold then starts
	// from the programmed value, which is what the estimate held until then.
	logic [15:0] idle_current_word;
	assign idle_current_word = 16'(-idle_est_ff);

	// Peak load tracking, held as a magnitude and reported as a discharge.
	logic [15:0] peak_mag_ff;
	logic peak_loaded_ff;
	logic deep_dsg_ff;
	logic full_prev_ff;
	logic full_rise;
	logic [16:0] peak_sum;
	assign full_rise = meas_i.full_charge && !full_prev_ff;
	assign peak_sum = {1'b0, peak_mag_ff} + {1'b0, cfg_i.init_max_load_ma};

	// The relaxation to the mean wins over growth in the same cycle; the next
	// larger sample grows it again one cycle later.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			peak_mag_ff <= 16'h0;
			peak_loaded_ff <= 1'b0;
			deep_dsg_ff <= 1'b0;
			full_prev_ff <= 1'b0;
		end else begin
			full_prev_ff <= meas_i.full_charge;
			if (!peak_loaded_ff) begin
				peak_mag_ff <= cfg_i.init_max_load_ma;
				peak_loaded_ff <= 1'b1;
			end else if (full_rise && deep_dsg_ff) begin
				peak_mag_ff <= peak_sum[16:1];
			end else if (dsg_mag > peak_mag_ff) begin
				peak_mag_ff <= dsg_mag;
			end
			if (full_rise) begin
				deep_dsg_ff <= 1'b0;
			end else if (meas_i.discharging && meas_i.charge_pct < HALF_CHARGE_PCT) begin
				deep_dsg_ff <= 1'b1;
			end
		end
	end

	// Fixed power runtime and instant current move only on the second tick.
	logic [15:0] fixed_runtime_ff;
	logic [15:0] instant_current_ff;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			fixed_runtime_ff <= NOT_AVAILABLE;
			instant_current_ff <= 16'h0;
		end else if (sec_tick) begin
			fixed_runtime_ff <= (meas_i.mean_power_mw == 16'sh0) ? NOT_AVAILABLE :
				meas_i.fixed_power_runtime_minutes;
			instant_current_ff <= meas_i.conv_current_ma;
		end
	end

	// Cycle counters, one per cell profile, each with its discharge accumulator.
	logic [15:0] cycle_cnt_ff [CELL_PROFILES];
	logic [31:0] dsg_acc_ff [CELL_PROFILES];
	generate
		for (genvar p = 0; p < CELL_PROFILES; p++) begin : g_profile
			logic active;
			logic [31:0] acc_sum;
			logic crossed;
			assign active = (cell_profile_i == 1'(p));
			assign acc_sum = dsg_acc_ff[p] + {16'h0, dsg_step_mah_i};
			assign crossed = acc_sum >= {16'h0, cfg_i.cycle_threshold_mah};
			// A new pack wipes the active profile; the threshold is subtracted so
			// leftover discharge carries into the next cycle.
			always_ff @(posedge core_clk_i) begin
				if (!resetn_i) begin
					cycle_cnt_ff[p] <= 16'h0;
					dsg_acc_ff[p] <= 32'h0;
				end else if (active && pack_inserted_i) begin
					cycle_cnt_ff[p] <= 16'h0;
					dsg_acc_ff[p] <= 32'h0;
				end else if (active && dsg_step_valid_i) begin
					if (crossed && cfg_i.cycle_threshold_mah != 16'h0) begin
						dsg_acc_ff[p] <= acc_sum - {16'h0, cfg_i.cycle_threshold_mah};
						if (cycle_cnt_ff[p] != CYCLE_COUNT_MAX) begin
							cycle_cnt_ff[p] <= cycle_cnt_ff[p] + 16'h1;
						end
					end else begin
						dsg_acc_ff[p] <= acc_sum;
					end
				end
			end
		end
	endgenerate

	// Data log control; only the two subcommands move the active bit.
	logic log_active_ff;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			log_active_ff <= 1'b0;
		end else if (log_on_subcommand_i) begin
			log_active_ff <= 1'b1;
		end else if (log_off_subcommand_i) begin
			log_active_ff <= 1'b0;
		end
	end
	assign log_active_bit_o = log_active_ff;
	assign sleep_inhibit_o = log_active_ff;

	// Log FIFO: 30 flip-flop slots, a read slot, a write slot and a fill count.
	logic [15:0] log_mem_ff [LOG_DEPTH];
	logic [4:0] log_rd_ff;
	logic [4:0] log_wr_ff;
	logic [4:0] log_cnt_ff;
	logic log_push;
	logic log_pop;
	logic snap_from_log_ff;

	// Samples arriving with a full FIFO are lost, never written over old ones.
	assign log_push = log_active_ff && cc_sample_valid_i &&
		(log_cnt_ff != LOG_FULL_COUNT);
	// Popping needs the odd byte of a word whose even byte caught a real sample.
	assign log_pop = rd_strobe_i && (cmd_addr_i == (ADDR_LOG_SAMPLE | 8'h01)) &&
		snap_from_log_ff && (log_cnt_ff != 5'h0);

	generate
		for (genvar s = 0; s < LOG_DEPTH; s++) begin : g_log_slot
			always_ff @(posedge core_clk_i) begin
				if (!resetn_i) begin
					log_mem_ff[s] <= 16'h0;
				end else if (log_push && log_wr_ff == 5'(s)) begin
					log_mem_ff[s] <= cc_sample_ma_i;
				end
			end
		end
	endgenerate

	// Log on empties the FIFO; a sample in that cycle is not captured.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i || log_on_subcommand_i) begin
			log_rd_ff <= 5'h0;
			log_wr_ff <= 5'h0;
			log_cnt_ff <= 5'h0;
		end else begin
			if (log_push) begin
				log_wr_ff <= (log_wr_ff == LOG_LAST_SLOT) ? 5'h0 : log_wr_ff + 5'h1;
			end
			if (log_pop) begin
				log_rd_ff <= (log_rd_ff == LOG_LAST_SLOT) ? 5'h0 : log_rd_ff + 5'h1;
			end
			if (log_push && !log_pop) begin
				log_cnt_ff <= log_cnt_ff + 5'h1;
			end else if (log_pop && !log_push) begin
				log_cnt_ff <= log_cnt_ff - 5'h1;
			end
		end
	end

	// Word views of the shaped results, with the time to full, idle runtime and peak runtime not-available values forced here.
	logic [15:0] ttf_word;
	logic [15:0] idle_runtime_word;
	logic [15:0] peak_runtime_word;
	logic [15:0] power_word;
	logic [15:0] health_word;
	logic [15:0] charge_word;
	logic [15:0] log_word;
	logic [15:0] cycle_word;
	logic log_empty;
	assign ttf_word = meas_i.charging ? meas_i.ttf_minutes : NOT_AVAILABLE;
	assign idle_runtime_word = meas_i.discharging ?
		meas_i.idle_runtime_minutes : NOT_AVAILABLE;
	assign peak_runtime_word = meas_i.discharging ?
		meas_i.peak_runtime_minutes : NOT_AVAILABLE;
	assign power_word = (meas_i.charging || meas_i.discharging) ?
		meas_i.mean_power_mw : 16'h0;
	// Reserved status codes read as not initialised rather than leak through.
	assign health_word = {
		(meas_i.health_status > HEALTH_STATUS_MAX) ? 8'h00 : meas_i.health_status,
		(meas_i.health_pct > HEALTH_PCT_MAX) ? HEALTH_PCT_MAX : meas_i.health_pct
	};
	assign charge_word = (meas_i.charge_pct > CHARGE_PCT_MAX) ?
		CHARGE_PCT_MAX : meas_i.charge_pct;
	assign log_empty = (log_cnt_ff == 5'h0);
	assign log_word = log_empty ? LOG_EMPTY_WORD : log_mem_ff[log_rd_ff];
	assign cycle_word = cycle_cnt_ff[cell_profile_i];

	// Word decode on the even address; unmapped addresses read as zero.
	logic [7:0] word_addr;
	logic [15:0] sel_word;
	assign word_addr = {cmd_addr_i[7:1], 1'b0};
	assign sel_word =
		(word_addr == ADDR_TIME_TO_FULL) ? ttf_word :
		(word_addr == ADDR_IDLE_CURRENT) ? idle_current_word :
		(word_addr == ADDR_IDLE_RUNTIME) ? idle_runtime_word :
		(word_addr == ADDR_PEAK_LOAD) ? 16'(-peak_mag_ff) :
		(word_addr == ADDR_PEAK_RUNTIME) ? peak_runtime_word :
		(word_addr == ADDR_MEAN_POWER) ? power_word :
		(word_addr == ADDR_FIXED_POWER_RUNTIME) ? fixed_runtime_ff :
		(word_addr == ADDR_HEALTH) ? health_word :
		(word_addr == ADDR_CYCLE_COUNT) ? cycle_word :
		(word_addr == ADDR_CHARGE_PERCENT) ? charge_word :
		(word_addr == ADDR_CELL_IMPEDANCE) ? meas_i.impedance_mohm :
		(word_addr == ADDR_INSTANT_CURRENT) ? instant_current_ff :
		(word_addr == ADDR_LOG_FILL) ? {11'h0, log_cnt_ff} :
		(word_addr == ADDR_LOG_SAMPLE) ? log_word :
		(word_addr == ADDR_DIE_TEMP) ? meas_i.die_temp_0p1k :
		UNMAPPED_WORD;

	// Byte read path: an even read returns the low byte and freezes the word so the
	// odd read that follows cannot tear; an odd read alone uses the last frozen word.
	logic [15:0] snap_word_ff;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			snap_word_ff <= 16'h0;
			snap_from_log_ff <= 1'b0;
			rd_data_o <= 8'h00;
		end else if (rd_strobe_i) begin
			if (!cmd_addr_i[0]) begin
				snap_word_ff <= sel_word;
				snap_from_log_ff <= (word_addr == ADDR_LOG_SAMPLE) && !log_empty;
				rd_data_o <= sel_word[7:0];
			end else begin
				rd_data_o <= snap_word_ff[15:8];
				snap_from_log_ff <= 1'b0;
			end
		end
	end

endmodule : gauge_result_registers

// File: sim/gauge_result_registers_asserts.sv
// Purpose: Port-level checker for the gauge result register bank.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Read data is checked one cycle after the taking edge.
`timescale 1ns/1ps
module gauge_result_checker import gauge_result_pkg::*; #(
	parameter int SECOND_CYCLES = SEC_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire gauge_meas_t meas_i,
	input wire logic log_on_subcommand_i,
	input wire logic log_off_subcommand_i,
	input wire logic rd_strobe_i,
	input wire logic [7:0] cmd_addr_i,
	input wire logic [7:0] rd_data_o,
	input wire logic log_active_bit_o,
	input wire logic sleep_inhibit_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// A read of the given address taken at this edge.
	function automatic logic rd_at(input logic [7:0] a);
		return rd_strobe_i && cmd_addr_i == a;
	endfunction : rd_at
	// The host reads a whole word, low byte first.
	sequence s_health_pair;
		rd_at(ADDR_HEALTH) ##1 rd_at(ADDR_HEALTH | 8'h01);
	endsequence
	property p_log_on; log_on_subcommand_i |=> log_active_bit_o; endproperty
	a_log_on: assert property (p_log_on) else $error("log on did not activate");
	property p_log_off;
		log_off_subcommand_i && !log_on_subcommand_i |=> !log_active_bit_o;
	endproperty
	a_log_off: assert property (p_log_off) else $error("log off did not stop");
	property p_log_hold;
		!log_on_subcommand_i && !log_off_subcommand_i |=> $stable(log_active_bit_o);
	endproperty
	a_log_hold: assert property (p_log_hold) else $error("log state moved alone");
	property p_sleep; sleep_inhibit_o == log_active_bit_o; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not held off while logging");
	property p_ttf; rd_at(ADDR_TIME_TO_FULL) && !meas_i.charging |=> rd_data_o == 8'hFF; endproperty
	a_ttf: assert property (p_ttf) else $error("time to full not 65535");
	property p_idle_rt;
		rd_at(ADDR_IDLE_RUNTIME) && !meas_i.discharging |=> rd_data_o == 8'hFF;
	endproperty
	a_idle_rt: assert property (p_idle_rt) else $error("idle runtime not 65535");
	property p_peak_rt;
		rd_at(ADDR_PEAK_RUNTIME) && !meas_i.discharging |=> rd_data_o == 8'hFF;
	endproperty
	a_peak_rt: assert property (p_peak_rt) else $error("peak runtime not 65535");
	property p_unmapped;
		rd_strobe_i && !cmd_addr_i[0] && (cmd_addr_i < 8'h18 || cmd_addr_i > 8'h37 ||
			cmd_addr_i == 8'h22) |=> rd_data_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pct; rd_at(ADDR_HEALTH) |=> rd_data_o <= HEALTH_PCT_MAX; endproperty
	a_pct: assert property (p_pct) else $error("health percent above limit");
	property p_status; s_health_pair |=> rd_data_o <= HEALTH_STATUS_MAX; endproperty
	a_status: assert property (p_status) else $error("reserved health status");
	property p_charge; rd_at(ADDR_CHARGE_PERCENT) |=> rd_data_o <= 8'h64; endproperty
	a_charge: assert property (p_charge) else $error("charge percent above 100");
endmodule : gauge_result_checker
bind gauge_result_registers gauge_result_checker #(.SECOND_CYCLES(SECOND_CYCLES)) chk_i (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .meas_i(meas_i),
	.log_on_subcommand_i(log_on_subcommand_i), .log_off_subcommand_i(log_off_subcommand_i),
	.rd_strobe_i(rd_strobe_i), .cmd_addr_i(cmd_addr_i), .rd_data_o(rd_data_o),
	.log_active_bit_o(log_active_bit_o), .sleep_inhibit_o(sleep_inhibit_o));

// File: sim/host_model.sv
// Purpose: Host side of the byte read port.
// Assumes: Signals change on the falling edge only.
// Notes: The idle address shows the inverse of the last one, never a stale copy.
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk_i,
	output logic rd_strobe_o,
	output logic [7:0] cmd_addr_o,
	input wire logic [7:0] rd_data_i
);
	initial begin
		rd_strobe_o = 1'b0;
		cmd_addr_o = 8'h00;
	end
	// Even byte first, then the odd byte back to back, so the word is frozen whole.
	task automatic read_word(input logic [7:0] a, output logic [15:0] w);
		@(negedge core_clk_i);
		rd_strobe_o = 1'b1;
		cmd_addr_o = a;
		@(negedge core_clk_i);
		cmd_addr_o = a | 8'h01;
		w[7:0] = rd_data_i;
		@(negedge core_clk_i);
		w[15:8] = rd_data_i;
		rd_strobe_o = 1'b0;
		cmd_addr_o = ~(a | 8'h01);
	endtask : read_word
endmodule : host_model

// File: sim/gauge_result_registers_test.sv
// Purpose: Self-checking bench for the gauge result register bank.
// Assumes: Short second tick of 16 cycles.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
module gauge_result_registers_test import gauge_result_pkg::*;;
	localparam int SC = 16;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	gauge_meas_t meas = '0;
	gauge_cfg_t cfg = '{16'h0010, 16'h0100, 16'h0004, 16'h0100};
	logic prof = 1'b0, pack = 1'b0, dv = 1'b0, cv = 1'b0, lon = 1'b0, loff = 1'b0;
	logic [15:0] dmah = 16'h0080;
	logic signed [15:0] cs = 16'sh0000;
	logic rd;
	logic [7:0] addr, rdat;
	logic act, slp;
	int fails = 0, tests_run = 0, cycles = 0;
	always #4 core_clk_i = ~core_clk_i;
	gauge_result_registers #(.SECOND_CYCLES(SC)) DUT (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .meas_i(meas), .cfg_i(cfg), .cell_profile_i(prof),
		.pack_inserted_i(pack), .dsg_step_valid_i(dv), .dsg_step_mah_i(dmah),
		.cc_sample_valid_i(cv), .cc_sample_ma_i(cs), .log_on_subcommand_i(lon),
		.log_off_subcommand_i(loff), .rd_strobe_i(rd), .cmd_addr_i(addr),
		.rd_data_o(rdat), .log_active_bit_o(act), .sleep_inhibit_o(slp));
	host_model HOST (.core_clk_i(core_clk_i), .rd_strobe_o(rd), .cmd_addr_o(addr),
		.rd_data_i(rdat));
	// Ends the run in one place with the counts and the verdict.
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] w;
		HOST.read_word(a, w);
		chk(w, e);
	endtask : rc
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : cyc
	// A hang is cut short well past the expected run length.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		cyc(3);
		resetn_i = 1'b1;
		rc(8'h18, 16'hFFFF);
		rc(8'h1C, 16'hFFFF);
		rc(8'h20, 16'hFFFF);
		rc(8'h1A, 16'hFFF0);
		rc(8'h1E, 16'hFF00);
		rc(8'h22, 16'h0000);
		rc(8'h34, 16'h7FFF);
		meas.mean_power_mw = 16'sh0123;
		rc(8'h24, 16'h0000);
		meas.charging = 1'b1;
		meas.ttf_minutes = 16'h0042;
		rc(8'h18, 16'h0042);
		meas.charging = 1'b0;
		meas.discharging = 1'b1;
		meas.idle_runtime_minutes = 16'h0111;
		meas.peak_runtime_minutes = 16'h0222;
		meas.mean_power_mw = 16'shFF00;
		meas.charge_pct = 16'h0010;
		meas.mean_current_ma = 16'shFE00;
		meas.conv_current_ma = 16'shFE00;
		rc(8'h1C, 16'h0111);
		rc(8'h20, 16'h0222);
		rc(8'h24, 16'hFF00);
		rc(8'h1E, 16'hFE00);
		// A full charge after a deep discharge pulls the peak halfway back.
		meas.mean_current_ma = 16'sh0000;
		meas.conv_current_ma = 16'shFFF6;
		meas.discharging = 1'b0;
		meas.charge_pct = 16'h0070;
		meas.full_charge = 1'b1;
		rc(8'h1E, 16'hFE80);
		rc(8'h2C, 16'h0064);
		meas.health_pct = 8'h70;
		meas.health_status = 8'h05;
		rc(8'h28, 16'h0064);
		meas.health_pct = 8'h40;
		meas.health_status = 8'h02;
		rc(8'h28, 16'h0240);
		meas.fixed_power_runtime_minutes = 16'h0333;
		meas.die_temp_0p1k = 16'h0BB8;
		meas.impedance_mohm = 16'h0055;
		cyc(SC + 2);
		rc(8'h30, 16'hFFF6);
		rc(8'h26, 16'h0333);
		rc(8'h36, 16'h0BB8);
		rc(8'h2E, 16'h0055);
		// A light load inside the standby window; the first samples must not count.
		meas.mean_current_ma = 16'shFFE0;
		meas.mean_power_mw = 16'sh0000;
		cyc(32);
		rc(8'h1A, 16'hFFF0);
		rc(8'h26, 16'hFFFF);
		// Fifteen sixteenths of 16 plus one sixteenth of 32 settles at 17 from the first fold.
		cyc(64);
		rc(8'h1A, 16'hFFEF);
		// Two half-threshold steps make exactly one cycle.
		dv = 1'b1;
		cyc(2);
		dv = 1'b0;
		rc(8'h2A, 16'h0001);
		prof = 1'b1;
		rc(8'h2A, 16'h0000);
		prof = 1'b0;
		rc(8'h2A, 16'h0001);
		pack = 1'b1;
		cyc(1);
		pack = 1'b0;
		rc(8'h2A, 16'h0000);
		// A sample while logging is off must be dropped.
		cv = 1'b1;
		cyc(1);
		cv = 1'b0;
		loff = 1'b1;
		cyc(1);
		loff = 1'b0;
		rc(8'h32, 16'h0000);
		lon = 1'b1;
		cyc(1);
		lon = 1'b0;
		cyc(1);
		chk({15'h0000, act}, 16'h0001);
		chk({15'h0000, slp}, 16'h0001);
		// One sample more than the depth overflows the log.
		cv = 1'b1;
		for (int i = 0; i < 31; i++) begin
			cs = 16'sh0100 + 16'(i);
			cyc(1);
		end
		cv = 1'b0;
		rc(8'h32, 16'h001E);
		rc(8'h34, 16'h0100);
		rc(8'h32, 16'h001D);
		loff = 1'b1;
		cyc(1);
		loff = 1'b0;
		cv = 1'b1;
		cyc(1);
		cv = 1'b0;
		rc(8'h32, 16'h001D);
		rc(8'h34, 16'h0101);
		lon = 1'b1;
		cyc(1);
		lon = 1'b0;
		rc(8'h32, 16'h0000);
		report_and_stop();
	end
endmodule : gauge_result_registers_test
